// [include/dtb_pkg.sv]
/*
  shared constants and types of the debug trigger and breakpoint block:
  trigger mode codes, storage sizes and reset values.
  assumes nothing beyond a synthesis tool that accepts packages.
*/
package dtb_pkg;

  // trace storage holds eight words of sixteen bits
  localparam int DTB_FIFO_DEPTH = 8;
  localparam int DTB_WORD_W = 16;
  // event-only data sits in the low byte
  localparam int DTB_DATA_W = 8;
  // opcodes the instruction queue may hold at once
  localparam int DTB_QUEUE_DEPTH = 3;

  // bus direction code for a write cycle
  localparam logic DTB_RW_WRITE = 1'b0;
  // begin trace select value in the trigger control register
  localparam logic DTB_BEGIN_TRACE = 1'b1;
  // break kind value for a tag request
  localparam logic DTB_BRK_TAG = 1'b1;

  // reset values of the run state
  localparam logic DTB_RST_ARMED = 1'b0;
  localparam logic DTB_RST_HIT = 1'b0;
  localparam logic DTB_RST_STORING = 1'b0;
  localparam logic DTB_RST_PEND = 1'b0;

  // the nine trigger modes of the four-bit mode field
  typedef enum logic [3:0] {
    DTB_MODE_A_ONLY = 4'h0,
    DTB_MODE_A_OR_B = 4'h1,
    DTB_MODE_A_THEN_B = 4'h2,
    DTB_MODE_EVENT_B = 4'h3,
    DTB_MODE_A_THEN_EVENT_B = 4'h4,
    DTB_MODE_A_AND_B_DATA = 4'h5,
    DTB_MODE_A_AND_NOT_B_DATA = 4'h6,
    DTB_MODE_INSIDE_RANGE = 4'h7,
    DTB_MODE_OUTSIDE_RANGE = 4'h8
  } dtb_mode_t;

endpackage : dtb_pkg

// [design/dtb_op_tracker.sv]
/*
  opcode tracker: follows one tag bit per opcode through the cpu
  instruction queue and reports when a tagged opcode executes.
  assumes fetch, exec and flush are single-cycle strobes from the core.
*/
`timescale 1ns/100ps
`default_nettype none

module dtb_op_tracker #(
  parameter int DEPTH = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetch,
  input wire logic tag_in,
  input wire logic flush,
  input wire logic exec,
  output logic exec_hit
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // one tag per queue slot, slot 0 is the head of the queue, next to execute
  logic [DEPTH-1:0] tags_ff;
  logic [DEPTH-1:0] nxt_tags;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  // queue state after the pop, before the push
  logic pop;
  logic [DEPTH-1:0] kept_tags;
  logic [CW-1:0] kept_cnt;

  assign pop = exec && (cnt_ff != '0);

  assign kept_tags = flush ? '0 : (pop ? (tags_ff >> 1) : tags_ff);
  assign kept_cnt = flush ? '0 : (cnt_ff - CW'(pop));

  assign exec_hit = pop && tags_ff[0] && !flush;

  // push the fetched opcode's tag behind the kept entries
  always_comb begin
    nxt_tags = kept_tags;
    nxt_cnt = kept_cnt;
    if (fetch && (kept_cnt < DEPTH_C)) begin
      nxt_tags[kept_cnt] = tag_in;
      nxt_cnt = kept_cnt + CW'(1);
    end
  end

  // queue tag registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tags_ff <= '0;
      cnt_ff <= '0;
    end else begin
      tags_ff <= nxt_tags;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : dtb_op_tracker

`default_nettype wire

// [design/dtb_trigger.sv]
/*
  debug trigger and breakpoint block: two comparators, nine trigger
  modes, trace storage control and breakpoint requests to the cpu.
  assumes control bits arrive as plain levels and the arm write as a
  one-cycle strobe, all synchronous to clk; the core reports fetch,
  execute, flush and instruction boundaries as one-cycle strobes.
*/
// Function
// - tags act only on executed opcodes
// - force break waits for instruction end
// - tagged opcode replaced by background entry
// - tag select routes comparators through trackers
// - four-bit field picks one of nine modes
// - begin select: start at trigger or circular
// - arm sets flag, clears hits and count
// - begin run ends full, end run on trigger
// - clearing arm or enable halts run
// - flow addresses, or data bytes in event modes
// - event modes always behave as begin trace
// - optional read/write qualification per comparator
// - break enable issues tag or force request
// - a-only and a-or-b address matches
// - b triggers only after earlier a match
// - full mode: address a plus data b
// - full mode: address a, data not b
// - tag break in full modes ignores data
// - event b stores data until full
// - after a, each b stores data
// - inside and outside address range modes
// - no background permit gives software interrupt
`timescale 1ns/100ps
`default_nettype none

module dtb_trigger
  import dtb_pkg::*;
#(
  parameter int FIFO_DEPTH = DTB_FIFO_DEPTH,
  parameter int QUEUE_DEPTH = DTB_QUEUE_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  // debug control register bits
  input wire logic debug_module_enable,
  input wire logic arm_write,
  input wire logic arm_value,
  input wire logic cpu_break_enable,
  input wire logic break_kind_tag,
  input wire logic rw_qualify_en_a,
  input wire logic rw_match_value_a,
  input wire logic rw_qualify_en_b,
  input wire logic rw_match_value_b,
  // trigger control register bits
  input wire logic [3:0] trigger_mode_field,
  input wire logic opcode_track_select,
  input wire logic trace_begin_select,
  // comparator values
  input wire logic [DTB_WORD_W-1:0] comp_a_value,
  input wire logic [DTB_WORD_W-1:0] comp_b_value,
  // serial controller permit for background mode
  input wire logic background_permit,
  // cpu bus cycle
  input wire logic bus_valid,
  input wire logic bus_rw,
  input wire logic [DTB_WORD_W-1:0] bus_addr,
  input wire logic [DTB_DATA_W-1:0] bus_read_data,
  input wire logic [DTB_DATA_W-1:0] bus_write_data,
  input wire logic bdc_access,
  // cpu instruction queue events
  input wire logic opcode_fetch,
  input wire logic queue_flush,
  input wire logic opcode_exec,
  input wire logic insn_boundary,
  // change-of-flow report
  input wire logic cof_valid,
  input wire logic [DTB_WORD_W-1:0] cof_addr,
  // trace readout
  input wire logic [$clog2(FIFO_DEPTH)-1:0] fifo_read_index,
  output logic [DTB_WORD_W-1:0] fifo_read_data_ff,
  // debug status register bits
  output logic run_active_flag_ff,
  output logic comp_a_hit_flag_ff,
  output logic comp_b_hit_flag_ff,
  output logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_word_count_ff,
  // cpu break actions
  output logic enter_background_opcode_ff,
  output logic software_interrupt_opcode_ff,
  output logic suppress_exec_ff
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [CW-1:0] FULL_C = CW'(FIFO_DEPTH);

  // mode decode
  dtb_mode_t mode;
  logic event_mode;
  logic full_mode;
  logic range_mode;
  // comparator raw matches
  logic addr_eq_a;
  logic addr_eq_b;
  logic data_eq_b;
  logic addr_in_range;
  logic rw_ok_a;
  logic rw_ok_b;
  logic [DTB_DATA_W-1:0] cmp_data;
  logic cmp_live;
  // qualified comparator signals before and after tracking
  logic qual_a;
  logic qual_b;
  logic track_a;
  logic track_b;
  logic sig_a;
  logic sig_b;
  // trigger results
  logic trig_raw;
  logic trig;
  logic tag_cond;
  logic tag_exec_hit;
  // run control
  logic run_live;
  logic start_run;
  logic stop_run;
  logic fifo_full;
  logic capture;
  logic [DTB_WORD_W-1:0] capture_word;
  logic storing_ff;
  logic force_pend_ff;
  logic [PW-1:0] wr_ptr_ff;
  // trace storage
  logic [DTB_WORD_W-1:0] fifo_mem [FIFO_DEPTH];

  assign mode = dtb_mode_t'(trigger_mode_field);
  assign event_mode = (mode == DTB_MODE_EVENT_B) || (mode == DTB_MODE_A_THEN_EVENT_B);
  assign full_mode = (mode == DTB_MODE_A_AND_B_DATA) || (mode == DTB_MODE_A_AND_NOT_B_DATA);
  assign range_mode = (mode == DTB_MODE_INSIDE_RANGE) || (mode == DTB_MODE_OUTSIDE_RANGE);

  // comparators sleep during serial controller accesses
  assign cmp_live = bus_valid && !bdc_access;
  assign addr_eq_a = bus_addr == comp_a_value;
  assign addr_eq_b = bus_addr == comp_b_value;
  // inclusive window between a and b
  assign addr_in_range = (bus_addr >= comp_a_value) && (bus_addr <= comp_b_value);
  // write data only when qualified for writes, else read data
  assign cmp_data = (rw_qualify_en_a && (rw_match_value_a == DTB_RW_WRITE)) ?
                    bus_write_data : bus_read_data;
  assign data_eq_b = cmp_data == comp_b_value[DTB_DATA_W-1:0];

  assign rw_ok_a = !rw_qualify_en_a || (bus_rw == rw_match_value_a);
  assign rw_ok_b = !rw_qualify_en_b || (bus_rw == rw_match_value_b);

  // comparator a carries the range test in range modes
  assign qual_a = cmp_live && rw_ok_a &&
                  (mode == DTB_MODE_INSIDE_RANGE ? addr_in_range :
                   mode == DTB_MODE_OUTSIDE_RANGE ? !addr_in_range : addr_eq_a);
  assign qual_b = cmp_live && rw_ok_b && addr_eq_b;

  dtb_op_tracker #(
    .DEPTH(QUEUE_DEPTH)
  ) u_track_a (
    .clk(clk),
    .resetn(resetn),
    .fetch(opcode_fetch),
    .tag_in(qual_a),
    .flush(queue_flush),
    .exec(opcode_exec),
    .exec_hit(track_a)
  );

  dtb_op_tracker #(
    .DEPTH(QUEUE_DEPTH)
  ) u_track_b (
    .clk(clk),
    .resetn(resetn),
    .fetch(opcode_fetch),
    .tag_in(qual_b),
    .flush(queue_flush),
    .exec(opcode_exec),
    .exec_hit(track_b)
  );

  assign sig_a = opcode_track_select ? track_a : qual_a;
  assign sig_b = opcode_track_select ? track_b : qual_b;

  // combine comparator signals under the selected mode
  always_comb begin
    trig_raw = 1'b0;
    unique case (mode)
      DTB_MODE_A_ONLY: trig_raw = sig_a;
      DTB_MODE_A_OR_B: trig_raw = sig_a || sig_b;
      DTB_MODE_A_THEN_B: trig_raw = sig_b && comp_a_hit_flag_ff;
      DTB_MODE_EVENT_B: trig_raw = sig_b;
      DTB_MODE_A_THEN_EVENT_B: trig_raw = sig_b && comp_a_hit_flag_ff;
      DTB_MODE_A_AND_B_DATA: trig_raw = sig_a && data_eq_b;
      DTB_MODE_A_AND_NOT_B_DATA: trig_raw = sig_a && !data_eq_b;
      // window tests ride on comparator a
      DTB_MODE_INSIDE_RANGE: trig_raw = sig_a;
      DTB_MODE_OUTSIDE_RANGE: trig_raw = sig_a;
      // codes nine to fifteen never trigger
      default: trig_raw = 1'b0;
    endcase
  end

  // triggers count only inside a live run
  assign run_live = run_active_flag_ff && debug_module_enable;
  assign trig = run_live && trig_raw;

  // tag request skips the data test
  assign tag_cond = run_live && cpu_break_enable && (break_kind_tag == DTB_BRK_TAG) &&
                    (full_mode ? qual_a :
                     (mode == DTB_MODE_A_OR_B) ? (qual_a || qual_b) :
                     (mode == DTB_MODE_A_THEN_B) ? (qual_b && comp_a_hit_flag_ff) :
                     (mode == DTB_MODE_A_ONLY) || range_mode ? qual_a : 1'b0);

  // cpu tag travels with the fetched opcode
  dtb_op_tracker #(
    .DEPTH(QUEUE_DEPTH)
  ) u_track_brk (
    .clk(clk),
    .resetn(resetn),
    .fetch(opcode_fetch),
    .tag_in(tag_cond),
    .flush(queue_flush),
    .exec(opcode_exec),
    .exec_hit(tag_exec_hit)
  );

  assign start_run = arm_write && arm_value && debug_module_enable;
  assign stop_run = (arm_write && !arm_value) || !debug_module_enable;

  assign fifo_full = fifo_word_count_ff == FULL_C;

  // event modes store bus data, others flow addresses
  assign capture = run_live && (event_mode ? trig : (storing_ff && cof_valid));
  assign capture_word = event_mode ? {{(DTB_WORD_W-DTB_DATA_W){1'b0}}, cmp_data} : cof_addr;

  // run flag and comparator hit flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_active_flag_ff <= DTB_RST_ARMED;
      comp_a_hit_flag_ff <= DTB_RST_HIT;
      comp_b_hit_flag_ff <= DTB_RST_HIT;
    end else if (start_run) begin
      run_active_flag_ff <= 1'b1;
      comp_a_hit_flag_ff <= 1'b0;
      comp_b_hit_flag_ff <= 1'b0;
    end else begin
      if (stop_run) begin
        run_active_flag_ff <= 1'b0;
      end else if (run_live && !event_mode && trace_begin_select != DTB_BEGIN_TRACE && trig) begin
        run_active_flag_ff <= 1'b0;
      end else if (run_live && fifo_full &&
                   (event_mode || trace_begin_select == DTB_BEGIN_TRACE)) begin
        run_active_flag_ff <= 1'b0;
      end
      comp_a_hit_flag_ff <= comp_a_hit_flag_ff || (run_live && sig_a);
      comp_b_hit_flag_ff <= comp_b_hit_flag_ff || (run_live && sig_b);
    end
  end

  // storage enable for flow address traces
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      storing_ff <= DTB_RST_STORING;
    end else if (start_run) begin
      // circular from arming unless begin trace
      storing_ff <= (trace_begin_select != DTB_BEGIN_TRACE);
    end else if (stop_run || !run_live) begin
      storing_ff <= 1'b0;
    end else if (trig && (trace_begin_select == DTB_BEGIN_TRACE)) begin
      // begin trace opens at the trigger
      storing_ff <= 1'b1;
    end
  end

  // event modes ignore begin select, stop at full
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fifo_word_count_ff <= '0;
      wr_ptr_ff <= '0;
    end else if (start_run) begin
      fifo_word_count_ff <= '0;
      wr_ptr_ff <= '0;
    end else if (capture && !(fifo_full && (event_mode || trace_begin_select == DTB_BEGIN_TRACE))) begin
      // end traces wrap and keep the count at full
      wr_ptr_ff <= (wr_ptr_ff == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
      fifo_word_count_ff <= fifo_full ? fifo_word_count_ff : fifo_word_count_ff + CW'(1);
    end
  end

  // trace storage write, no reset needed
  always_ff @(posedge clk) begin
    if (capture && !start_run &&
        !(fifo_full && (event_mode || trace_begin_select == DTB_BEGIN_TRACE))) begin
      fifo_mem[wr_ptr_ff] <= capture_word;
    end
  end

  // registered readout of one stored word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fifo_read_data_ff <= '0;
    end else begin
      fifo_read_data_ff <= fifo_mem[fifo_read_index];
    end
  end

  // force request waits for the boundary
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_pend_ff <= DTB_RST_PEND;
    end else if (trig && cpu_break_enable && (break_kind_tag != DTB_BRK_TAG)) begin
      // force kind selected; set wins over service
      force_pend_ff <= 1'b1;
    end else if (insn_boundary) begin
      force_pend_ff <= 1'b0;
    end
  end

  // break actions toward the core, one-cycle pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enter_background_opcode_ff <= 1'b0;
      software_interrupt_opcode_ff <= 1'b0;
      suppress_exec_ff <= 1'b0;
    end else begin
      enter_background_opcode_ff <= (tag_exec_hit || (force_pend_ff && insn_boundary)) &&
                                    background_permit;
      software_interrupt_opcode_ff <= (tag_exec_hit || (force_pend_ff && insn_boundary)) &&
                                      !background_permit;
      suppress_exec_ff <= tag_exec_hit;
    end
  end

endmodule : dtb_trigger

`default_nettype wire

// [dv/dtb_trigger_properties.sv]
/* port assertions of the trigger and breakpoint block.
   assumes a bind from the bench, one clock and an async low reset. */
`timescale 1ns/100ps
`default_nettype none
module dtb_trigger_properties
  import dtb_pkg::*;
#(
  parameter int FIFO_DEPTH = DTB_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic debug_module_enable,
  input wire logic arm_write,
  input wire logic arm_value,
  input wire logic rw_qualify_en_a,
  input wire logic [3:0] trigger_mode_field,
  input wire logic opcode_track_select,
  input wire logic trace_begin_select,
  input wire logic [DTB_WORD_W-1:0] comp_a_value,
  input wire logic background_permit,
  input wire logic bus_valid,
  input wire logic [DTB_WORD_W-1:0] bus_addr,
  input wire logic bdc_access,
  input wire logic opcode_exec,
  input wire logic insn_boundary,
  input wire logic run_active_flag_ff,
  input wire logic comp_a_hit_flag_ff,
  input wire logic comp_b_hit_flag_ff,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_word_count_ff,
  input wire logic enter_background_opcode_ff,
  input wire logic software_interrupt_opcode_ff,
  input wire logic suppress_exec_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // arm write that starts a run
  sequence s_start;
    debug_module_enable && arm_write && arm_value;
  endsequence
  // plain address match on comparator a in a live run
  sequence s_a_hit;
    run_active_flag_ff && debug_module_enable && !arm_write && bus_valid && !bdc_access
      && bus_addr == comp_a_value && !rw_qualify_en_a && !opcode_track_select
      && trigger_mode_field < 4'h7;
  endsequence
  property p_arm;
    s_start |=> run_active_flag_ff && !comp_a_hit_flag_ff && !comp_b_hit_flag_ff
      && fifo_word_count_ff == '0;
  endproperty
  a_arm: assert property (p_arm) else $error("arm did not reset the run");
  property p_stop;
    (arm_write && !arm_value) || !debug_module_enable |=> !run_active_flag_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("run not halted");
  property p_full;
    run_active_flag_ff && fifo_word_count_ff == FIFO_DEPTH && !arm_write
      && (trace_begin_select || trigger_mode_field inside {4'h3, 4'h4})
      |=> !run_active_flag_ff;
  endproperty
  a_full: assert property (p_full) else $error("full run kept going");
  property p_a_hit;
    s_a_hit |=> comp_a_hit_flag_ff;
  endproperty
  a_a_hit: assert property (p_a_hit) else $error("a match not flagged");
  property p_end_trace;
    s_a_hit ##0 (trigger_mode_field == 4'h0 && !trace_begin_select)
      |=> ##[0:1] !run_active_flag_ff;
  endproperty
  a_end_trace: assert property (p_end_trace) else $error("end trace not ended");
  property p_permit;
    enter_background_opcode_ff || software_interrupt_opcode_ff
      |-> enter_background_opcode_ff == $past(background_permit)
      && !(enter_background_opcode_ff && software_interrupt_opcode_ff);
  endproperty
  a_permit: assert property (p_permit) else $error("wrong break action");
  property p_force;
    (enter_background_opcode_ff || software_interrupt_opcode_ff) && !suppress_exec_ff
      |-> $past(insn_boundary);
  endproperty
  a_force: assert property (p_force) else $error("force break off boundary");
  property p_tag;
    suppress_exec_ff |-> $past(opcode_exec)
      && (enter_background_opcode_ff || software_interrupt_opcode_ff);
  endproperty
  a_tag: assert property (p_tag) else $error("tag break without execute");
endmodule : dtb_trigger_properties
`default_nettype wire

// [dv/dtb_cpu_model.sv]
/* behavioural cpu queue: fetch, execute, flush and boundary strobes.
   assumes bench requests on rising edges; halts on a break pulse. */
`timescale 1ns/100ps
`default_nettype none
module dtb_cpu_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetch_req,
  input wire logic exec_req,
  input wire logic flush_req,
  input wire logic slow,
  input wire logic enter_background_opcode_ff,
  input wire logic software_interrupt_opcode_ff,
  output logic opcode_fetch,
  output logic opcode_exec,
  output logic queue_flush,
  output logic insn_boundary,
  output logic halted
);
  logic [1:0] q_ff; // opcodes held in queue
  logic [1:0] bnd_ff; // boundary delay line
  assign opcode_fetch = fetch_req && !halted && q_ff < 2'h3;
  assign opcode_exec = exec_req && !halted && q_ff != 2'h0;
  assign queue_flush = flush_req && !halted;
  assign insn_boundary = slow ? bnd_ff[1] : bnd_ff[0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_ff <= 2'h0;
      bnd_ff <= 2'h0;
      halted <= 1'b0;
    end else begin
      q_ff <= queue_flush ? 2'h0 : q_ff + {1'b0, opcode_fetch} - {1'b0, opcode_exec};
      bnd_ff <= {bnd_ff[0], opcode_exec};
      halted <= (halted && !flush_req) || enter_background_opcode_ff
        || software_interrupt_opcode_ff;
    end
  end
endmodule : dtb_cpu_model
`default_nettype wire

// [dv/dtb_testbench.sv]
/* self-checking bench of the trigger block with a cpu queue model.
   assumes default parameters: eight trace words, queue of three. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dtb_pkg::*;
  logic clk, resetn, debug_module_enable, arm_write, arm_value, cpu_break_enable;
  logic break_kind_tag, rw_qualify_en_a, rw_match_value_a, rw_qualify_en_b;
  logic rw_match_value_b, opcode_track_select, trace_begin_select, background_permit;
  logic bus_valid, bus_rw, bdc_access, cof_valid, fetch_req, exec_req, flush_req, slow;
  logic opcode_fetch, queue_flush, opcode_exec, insn_boundary, halted;
  logic run_active_flag_ff, comp_a_hit_flag_ff, comp_b_hit_flag_ff;
  logic enter_background_opcode_ff, software_interrupt_opcode_ff, suppress_exec_ff;
  logic [3:0] trigger_mode_field, fifo_word_count_ff;
  logic [15:0] comp_a_value, comp_b_value, bus_addr, cof_addr, fifo_read_data_ff, keep;
  logic [7:0] bus_read_data, bus_write_data;
  logic [2:0] fifo_read_index;
  logic [2:0] exp_q[$]; // expected break {bg, swi, suppress}
  logic [31:0] rnd;
  logic [21:0] tbl[12]; // {mode, address, bus_rw, run after}
  int fail_count, n_tests;
  dtb_trigger u_dut (.*);
  dtb_cpu_model u_cpu (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] st();
    return {9'h0, run_active_flag_ff, comp_a_hit_flag_ff, comp_b_hit_flag_ff,
      fifo_word_count_ff};
  endfunction : st
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t expected %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic arm(input logic v);
    @(posedge clk);
    arm_write <= 1'b1;
    arm_value <= v;
    @(posedge clk);
    arm_write <= 1'b0;
  endtask : arm
  // one bus cycle, read bus d and write bus its inverse
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic f);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_read_data <= d;
    bus_write_data <= ~d;
    fetch_req <= f;
    @(posedge clk);
    bus_valid <= 1'b0;
    fetch_req <= 1'b0;
  endtask : bus
  task automatic cpu(input logic fl);
    @(posedge clk);
    exec_req <= !fl;
    flush_req <= fl;
    @(posedge clk);
    exec_req <= 1'b0;
    flush_req <= 1'b0;
    tick(3);
  endtask : cpu
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // break pulses compared against the oldest note
  always @(negedge clk) begin
    if (enter_background_opcode_ff || software_interrupt_opcode_ff) begin
      if (exp_q.size() == 0) chk(16'h0, 16'h1);
      else chk({13'h0, exp_q.pop_front()}, {13'h0, enter_background_opcode_ff,
        software_interrupt_opcode_ff, suppress_exec_ff});
    end
  end
  initial begin
    #800000;
    fail_count++;
    finish_test();
  end
  initial begin
    {resetn, arm_write, arm_value, cpu_break_enable, break_kind_tag, rw_qualify_en_a} = '0;
    {rw_match_value_a, rw_qualify_en_b, rw_match_value_b, opcode_track_select} = '0;
    {bus_valid, bus_rw, bdc_access, cof_valid, fetch_req, exec_req, flush_req, slow} = '0;
    {bus_addr, cof_addr, bus_read_data, bus_write_data, fifo_read_index} = '0;
    {debug_module_enable, trace_begin_select, background_permit} = 3'h7;
    trigger_mode_field = 4'h0;
    comp_a_value = 16'h1000;
    comp_b_value = 16'h2055;
    rnd = 32'h00012b5d;
    tbl = '{{4'h0, 16'h1000, 2'h0}, {4'h0, 16'h1000, 2'h3}, {4'h1, 16'h2055, 2'h0},
      {4'h2, 16'h2055, 2'h1}, {4'h2, 16'h2055, 2'h0}, {4'h5, 16'h1000, 2'h0},
      {4'h6, 16'h1000, 2'h1}, {4'h7, 16'h1800, 2'h0}, {4'h7, 16'h2056, 2'h1},
      {4'h8, 16'h1800, 2'h1}, {4'h8, 16'h0fff, 2'h0}, {4'h9, 16'h1000, 2'h1}};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    tick(1);
    chk(16'h0, st());
    cpu_break_enable <= 1'b1;
    comp_a_value <= 16'h0400;
    for (int p = 1; p >= 0; p--) begin
      background_permit <= p[0];
      slow <= !p[0];
      arm(1'b1);
      exp_q.push_back({p[0], !p[0], 1'b0});
      bus(16'h0400, 8'h00, 1'b1);
      cpu(1'b0);
      chk(16'h0060, st());
      cpu(1'b1);
    end
    // flushed tag is dropped, executed tag breaks
    break_kind_tag <= 1'b1;
    background_permit <= 1'b1;
    arm(1'b1);
    bus(16'h0400, 8'h00, 1'b1);
    cpu(1'b1);
    bus(16'h0300, 8'h00, 1'b1);
    cpu(1'b0);
    exp_q.push_back(3'h5);
    bus(16'h0400, 8'h00, 1'b1);
    cpu(1'b0);
    cpu(1'b1);
    chk(16'h0, 16'(exp_q.size()));
    $display("test breaks done");
    // begin trace of eight flow addresses
    cpu_break_enable <= 1'b0;
    trigger_mode_field <= 4'h1;
    arm(1'b1);
    bus(16'h2055, 8'h00, 1'b0);
    tick(2);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      if (i == 0) keep = rnd[15:0];
      @(posedge clk);
      cof_valid <= 1'b1;
      cof_addr <= rnd[15:0];
    end
    @(posedge clk);
    cof_valid <= 1'b0;
    fifo_read_index <= 3'h0;
    tick(3);
    chk(16'h0018, st());
    chk(keep, fifo_read_data_ff);
    $display("test begin trace done");
    // event b stores read bytes until full
    trigger_mode_field <= 4'h3;
    trace_begin_select <= 1'b0;
    comp_b_value <= 16'h3000;
    arm(1'b1);
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      if (i == 3) keep = {8'h00, rnd[7:0]};
      bus(16'h3000, rnd[7:0], 1'b0);
    end
    fifo_read_index <= 3'h3;
    tick(3);
    chk(16'h0018, st());
    chk(keep, fifo_read_data_ff);
    $display("test event trace done");
    // mode table, end traces, write-cycle qualified
    comp_a_value <= 16'h1000;
    comp_b_value <= 16'h2055;
    foreach (tbl[k]) begin
      @(posedge clk);
      // first row unqualified, the rest write-cycle qualified
      rw_qualify_en_a <= (k > 0);
      trigger_mode_field <= tbl[k][21:18];
      bus_rw <= tbl[k][1];
      arm(1'b1);
      if (k == 4) bus(16'h1000, 8'haa, 1'b0);
      bus(tbl[k][17:2], 8'haa, 1'b0);
      tick(2);
      chk({15'h0, tbl[k][0]}, {15'h0, run_active_flag_ff});
    end
    $display("test modes done");
    // tracked a match triggers only once executed
    opcode_track_select <= 1'b1;
    trigger_mode_field <= 4'h0;
    arm(1'b1);
    bus(16'h1000, 8'h00, 1'b1);
    cpu(1'b1);
    chk(16'h0040, st());
    bus(16'h1000, 8'h00, 1'b1);
    cpu(1'b0);
    chk(16'h0020, st());
    $display("test tracking done");
    opcode_track_select <= 1'b0;
    trigger_mode_field <= 4'h0;
    trace_begin_select <= 1'b1;
    arm(1'b1);
    arm(1'b0);
    tick(1);
    chk(16'h0, st());
    arm(1'b1);
    @(posedge clk);
    debug_module_enable <= 1'b0;
    arm(1'b1);
    tick(1);
    chk(16'h0, {15'h0, run_active_flag_ff});
    $display("test halts done");
    // reset in the middle of an armed run
    debug_module_enable <= 1'b1;
    arm(1'b1);
    resetn <= 1'b0;
    tick(1);
    resetn <= 1'b1;
    tick(2);
    chk(16'h0, st());
    $display("test reset done");
    finish_test();
  end
endmodule : testbench
bind dtb_trigger dtb_trigger_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);
`default_nettype wire
